// File: logic/tcu_consts.svh
// Offsets, field positions and reset values of the trigger target block.
// Assumes inclusion by bare name from the design and its package users.
`ifndef TCU_CONSTS_SVH
`define TCU_CONSTS_SVH

// Register indices; byte address is four times the index
`define TCU_IDX_ACTIVE 10'h202
`define TCU_IDX_DONE 10'h204
`define TCU_IDX_EN 10'h206
`define TCU_IDX_SRST 10'h208
`define TCU_IDX_PPS 10'h20a
`define TCU_IDX_NSL 10'h220
`define TCU_IDX_NSH 10'h222
`define TCU_IDX_SL 10'h224
`define TCU_IDX_SH 10'h226
`define TCU_IDX_CFG1 10'h228
`define TCU_IDX_U12W 10'h38a

// Field positions
`define TCU_POS_RANGE 11
`define TCU_POS_COMP_HI 10
`define TCU_POS_COMP_LO 8
`define TCU_POS_CASC 15
`define TCU_POS_TAIL 14
`define TCU_UNITS 12

// Reset values
`define TCU_RST_16 16'h0000
`define TCU_RST_UNITS 12'h000

`endif

// File: logic/tcu_pkg.sv
// Types shared by the trigger target block.
// Assumes tcu_consts.svh supplies the numeric constants.
package tcu_pkg;

	// Register selected by a bus address
	typedef enum {
		SEL_NONE, SEL_ACTIVE, SEL_DONE, SEL_EN, SEL_SRST, SEL_PPS,
		SEL_NSL, SEL_NSH, SEL_SL, SEL_SH, SEL_CFG1, SEL_U12W
	} tcu_sel_t;

	// Trigger unit 1 states
	typedef enum {
		U_IDLE, U_ARMED, U_REARM
	} tcu_state_t;

endpackage : tcu_pkg

// File: logic/tcu_target_cfg.sv
// Trigger unit 1 target time, delay compensation and unit 12 width config.
// Assumes an APB master on core_clk and a local time counter on core_clk.
//
// Register access over APB was chosen for this implementation.
`timescale 1ns/1ps
`include "tcu_consts.svh"

////////////////////////////////////////////////////////////////////////////////

// Function
// - Bits 10:8 shift output; bit 11 picks range
// - Unit 12 width is 24 bits, split
// - Target nanoseconds 30 bits; top two read zero
// - Target seconds 32 bits over two halves
// - Config bit 15 joins cascade; default clear
// - Enable bit clears after trigger fires, unless looping
// - All cascade without tail loops forever
// - Soft reset returns unit to defaults
module tcu_target_cfg (
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Local time counter
	input wire logic [31:0] local_sec,
	input wire logic [29:0] local_ns,
	// Trigger side
	output logic trig_out,
	output logic trig_active,
	output logic [4:0] delay_comp_ns,
	output logic [23:0] pps_width_u12
);

	////////////////////////////////////////////////////////////////////////////
	// Address decode, shared by read and write paths
	function automatic tcu_pkg::tcu_sel_t tcu_decode(input logic [11:0] a);
		tcu_pkg::tcu_sel_t s;
		s = tcu_pkg::SEL_NONE;
		unique case (a)
			{`TCU_IDX_ACTIVE, 2'b00}: s = tcu_pkg::SEL_ACTIVE;
			{`TCU_IDX_DONE, 2'b00}: s = tcu_pkg::SEL_DONE;
			{`TCU_IDX_EN, 2'b00}: s = tcu_pkg::SEL_EN;
			{`TCU_IDX_SRST, 2'b00}: s = tcu_pkg::SEL_SRST;
			{`TCU_IDX_PPS, 2'b00}: s = tcu_pkg::SEL_PPS;
			{`TCU_IDX_NSL, 2'b00}: s = tcu_pkg::SEL_NSL;
			{`TCU_IDX_NSH, 2'b00}: s = tcu_pkg::SEL_NSH;
			{`TCU_IDX_SL, 2'b00}: s = tcu_pkg::SEL_SL;
			{`TCU_IDX_SH, 2'b00}: s = tcu_pkg::SEL_SH;
			{`TCU_IDX_CFG1, 2'b00}: s = tcu_pkg::SEL_CFG1;
			{`TCU_IDX_U12W, 2'b00}: s = tcu_pkg::SEL_U12W;
			default: s = tcu_pkg::SEL_NONE; // Unmapped word
		endcase
		return s;
	endfunction : tcu_decode

	////////////////////////////////////////////////////////////////////////////
	// State
	logic pready_q, pready_d; // Access phase answer
	logic pslverr_q, pslverr_d; // Unmapped flag
	logic [31:0] prdata_q, prdata_d; // Read data
	logic [2:0] comp_q, comp_d; // Path delay code
	logic range_q, range_d; // Fine range select
	logic [7:0] pps_hi_q, pps_hi_d; // Unit 12 width top byte
	logic [15:0] u12w_q, u12w_d; // Unit 12 width low half
	logic [29:0] tns_q, tns_d; // Target nanoseconds
	logic [31:0] tsec_q, tsec_d; // Target seconds
	logic casc_q, casc_d; // Cascade member
	logic tail_q, tail_d; // Chain tail
	logic [11:0] en_q, en_d; // Unit enables
	logic [11:0] srst_q, srst_d; // Self clearing resets
	logic [11:0] done_q, done_d; // Event done, write one to clear
	tcu_pkg::tcu_state_t st_q, st_d; // Unit 1 state
	logic trig_q, trig_d; // Output pulse
	logic act_q, act_d; // Active status
	logic [4:0] dly_q, dly_d; // Compensation in ns
	logic [23:0] ppsw_q, ppsw_d; // Combined width

	// Decode and bus qualifiers
	tcu_pkg::tcu_sel_t sel;
	logic wr; // Write takes effect this edge
	logic [4:0] comp_ns; // Compensation in ns
	logic [30:0] tgt_ns; // Effective target ns
	logic reached; // Local time at or past target
	logic loop; // Endless cascade
	logic fire; // Trigger this cycle

	assign sel = tcu_decode(paddr);
	assign wr = psel && penable && pready_q && pwrite;

	// Step 1 ns when range bit set, 4 ns when clear
	assign comp_ns = range_q ? {2'b00, comp_q} : {comp_q, 2'b00};
	// Compensation shifts the compare point; sub-cycle shifts land on a clock edge
	assign tgt_ns = {1'b0, tns_q} + {26'h0, comp_ns};
	assign reached = (local_sec > tsec_q)
		|| ((local_sec == tsec_q) && ({1'b0, local_ns} >= tgt_ns));
	// Only unit 1 lives here, so it alone is the whole chain
	assign loop = casc_q && !tail_q;
	assign fire = (st_q == tcu_pkg::U_ARMED) && en_q[0] && reached;

	////////////////////////////////////////////////////////////////////////////
	// APB answer: one access cycle, data sampled in setup
	always_comb begin
		pready_d = 1'b0;
		pslverr_d = 1'b0;
		prdata_d = prdata_q;
		if (psel && !penable) begin
			pready_d = 1'b1;
			pslverr_d = (sel == tcu_pkg::SEL_NONE);
			prdata_d = 32'h0000_0000;
			unique case (sel)
				tcu_pkg::SEL_ACTIVE: prdata_d = {31'h0, act_q};
				tcu_pkg::SEL_DONE: prdata_d = {20'h0, done_q};
				tcu_pkg::SEL_EN: prdata_d = {20'h0, en_q};
				tcu_pkg::SEL_SRST: prdata_d = {20'h0, srst_q};
				tcu_pkg::SEL_PPS: prdata_d = {20'h0, range_q, comp_q, pps_hi_q};
				tcu_pkg::SEL_NSL: prdata_d = {16'h0, tns_q[15:0]};
				tcu_pkg::SEL_NSH: prdata_d = {18'h0, tns_q[29:16]};
				tcu_pkg::SEL_SL: prdata_d = {16'h0, tsec_q[15:0]};
				tcu_pkg::SEL_SH: prdata_d = {16'h0, tsec_q[31:16]};
				tcu_pkg::SEL_CFG1: prdata_d = {16'h0, casc_q, tail_q, 14'h0};
				tcu_pkg::SEL_U12W: prdata_d = {16'h0, u12w_q};
				tcu_pkg::SEL_NONE: prdata_d = 32'h0000_0000;
			endcase
		end
	end

	// Register the bus answer
	always_ff @(posedge core_clk) begin
		if (rst) begin
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q <= 32'h0000_0000;
		end else begin
			pready_q <= pready_d;
			pslverr_q <= pslverr_d;
			prdata_q <= prdata_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Configuration and unit 1 next state
	always_comb begin
		comp_d = comp_q;
		range_d = range_q;
		pps_hi_d = pps_hi_q;
		u12w_d = u12w_q;
		tns_d = tns_q;
		tsec_d = tsec_q;
		casc_d = casc_q;
		tail_d = tail_q;
		en_d = en_q;
		srst_d = `TCU_RST_UNITS; // Reset bits last one cycle
		done_d = done_q;
		st_d = st_q;
		trig_d = 1'b0;
		// Unit 1 sequencer
		unique case (st_q)
			tcu_pkg::U_IDLE: begin
				if (en_q[0]) begin
					st_d = tcu_pkg::U_ARMED;
				end
			end
			tcu_pkg::U_ARMED: begin
				if (!en_q[0]) begin
					st_d = tcu_pkg::U_IDLE;
				end else if (fire) begin
					trig_d = 1'b1;
					if (loop) begin
						st_d = tcu_pkg::U_REARM;
					end else begin
						en_d[0] = 1'b0;
						st_d = tcu_pkg::U_IDLE;
					end
				end
			end
			tcu_pkg::U_REARM: begin
				// Wait until time falls below target so the loop fires once a pass
				if (!en_q[0]) begin
					st_d = tcu_pkg::U_IDLE;
				end else if (!reached) begin
					st_d = tcu_pkg::U_ARMED;
				end
			end
		endcase
		// Bus writes; a write to the enable word beats the self clear
		if (wr) begin
			unique case (sel)
				tcu_pkg::SEL_DONE: done_d = done_q & ~pwdata[11:0];
				tcu_pkg::SEL_EN: en_d = pwdata[11:0];
				tcu_pkg::SEL_SRST: srst_d = pwdata[11:0];
				tcu_pkg::SEL_PPS: begin
					range_d = pwdata[`TCU_POS_RANGE];
					comp_d = pwdata[`TCU_POS_COMP_HI:`TCU_POS_COMP_LO];
					pps_hi_d = pwdata[7:0];
				end
				tcu_pkg::SEL_NSL: tns_d[15:0] = pwdata[15:0];
				tcu_pkg::SEL_NSH: tns_d[29:16] = pwdata[13:0];
				tcu_pkg::SEL_SL: tsec_d[15:0] = pwdata[15:0];
				tcu_pkg::SEL_SH: tsec_d[31:16] = pwdata[15:0];
				tcu_pkg::SEL_CFG1: begin
					casc_d = pwdata[`TCU_POS_CASC];
					tail_d = pwdata[`TCU_POS_TAIL];
				end
				tcu_pkg::SEL_U12W: u12w_d = pwdata[15:0];
				default: begin
					// Read only or unmapped: nothing stored
				end
			endcase
		end
		// Event done sets after the clear, so a same cycle event survives
		if (fire) begin
			done_d[0] = 1'b1;
		end
		// Soft reset of unit 1 overrides its sequencer and any same cycle write to its registers, stopping any loop
		if (srst_q[0]) begin
			tns_d = 30'h0;
			tsec_d = {`TCU_RST_16, `TCU_RST_16};
			casc_d = 1'b0;
			tail_d = 1'b0;
			en_d[0] = 1'b0;
			done_d[0] = 1'b0;
			st_d = tcu_pkg::U_IDLE;
			trig_d = 1'b0;
		end
		act_d = (st_d != tcu_pkg::U_IDLE);
		dly_d = comp_ns;
		ppsw_d = {pps_hi_q, u12w_q};
	end

	// Register configuration and unit state
	always_ff @(posedge core_clk) begin
		if (rst) begin
			comp_q <= 3'h0;
			range_q <= 1'b0;
			pps_hi_q <= 8'h00;
			u12w_q <= `TCU_RST_16;
			tns_q <= 30'h0;
			tsec_q <= 32'h0000_0000;
			casc_q <= 1'b0;
			tail_q <= 1'b0;
			en_q <= `TCU_RST_UNITS;
			srst_q <= `TCU_RST_UNITS;
			done_q <= `TCU_RST_UNITS;
			st_q <= tcu_pkg::U_IDLE;
			trig_q <= 1'b0;
			act_q <= 1'b0;
			dly_q <= 5'h00;
			ppsw_q <= 24'h00_0000;
		end else begin
			comp_q <= comp_d;
			range_q <= range_d;
			pps_hi_q <= pps_hi_d;
			u12w_q <= u12w_d;
			tns_q <= tns_d;
			tsec_q <= tsec_d;
			casc_q <= casc_d;
			tail_q <= tail_d;
			en_q <= en_d;
			srst_q <= srst_d;
			done_q <= done_d;
			st_q <= st_d;
			trig_q <= trig_d;
			act_q <= act_d;
			dly_q <= dly_d;
			ppsw_q <= ppsw_d;
		end
	end

	// Outputs straight from flops
	assign prdata = prdata_q;
	assign pready = pready_q;
	assign pslverr = pslverr_q;
	assign trig_out = trig_q;
	assign trig_active = act_q;
	assign delay_comp_ns = dly_q;
	assign pps_width_u12 = ppsw_q;

	////////////////////////////////////////////////////////////////////////////
	// Checks
	property p_delay;
		@(posedge core_clk) disable iff (rst)
		(wr && sel == tcu_pkg::SEL_PPS) |-> ##2 (delay_comp_ns == ($past(pwdata[11], 2)
			? {2'b00, $past(pwdata[10:8], 2)} : {$past(pwdata[10:8], 2), 2'b00}));
	endproperty
	a_delay: assert property (p_delay) else $error("delay compensation wrong");

	property p_ppsw;
		@(posedge core_clk) disable iff (rst)
		(wr && sel == tcu_pkg::SEL_U12W) |-> ##2 (pps_width_u12[15:0] == $past(pwdata[15:0], 2));
	endproperty
	a_ppsw: assert property (p_ppsw) else $error("unit 12 width wrong");

	property p_nsh_read;
		@(posedge core_clk) disable iff (rst)
		(psel && !penable && sel == tcu_pkg::SEL_NSH) |=> (prdata[31:14] == 18'h0)
			&& (prdata[13:0] == $past(tns_q[29:16]));
	endproperty
	a_nsh_read: assert property (p_nsh_read) else $error("ns high read wrong");

	property p_sech;
		@(posedge core_clk) disable iff (rst)
		(wr && sel == tcu_pkg::SEL_SH && !srst_q[0]) |=> (tsec_q[31:16] == $past(pwdata[15:0]));
	endproperty
	a_sech: assert property (p_sech) else $error("seconds high not stored");

	property p_casc;
		@(posedge core_clk) disable iff (rst)
		$rose(casc_q) |-> $past(wr && sel == tcu_pkg::SEL_CFG1 && pwdata[15]);
	endproperty
	a_casc: assert property (p_casc) else $error("cascade set without write");

	property p_fire;
		@(posedge core_clk) disable iff (rst)
		(fire && !srst_q[0]) |=> trig_out ##1 !trig_out;
	endproperty
	a_fire: assert property (p_fire) else $error("trigger pulse missing");

	property p_selfclr;
		@(posedge core_clk) disable iff (rst)
		(fire && !loop && !(wr && sel == tcu_pkg::SEL_EN)) |=> !en_q[0];
	endproperty
	a_selfclr: assert property (p_selfclr) else $error("enable not cleared");

	property p_loop;
		@(posedge core_clk) disable iff (rst)
		(fire && loop && !srst_q[0] && !wr) |=> en_q[0] && (st_q == tcu_pkg::U_REARM);
	endproperty
	a_loop: assert property (p_loop) else $error("loop did not rearm");

	property p_srst;
		@(posedge core_clk) disable iff (rst)
		srst_q[0] |=> (st_q == tcu_pkg::U_IDLE) && !en_q[0] && !casc_q && (tsec_q == 32'h0);
	endproperty
	a_srst: assert property (p_srst) else $error("soft reset incomplete");

	c_fire: cover property (@(posedge core_clk) disable iff (rst) fire && !loop);
	c_loop: cover property (@(posedge core_clk) disable iff (rst) fire && loop);
	c_srst: cover property (@(posedge core_clk) disable iff (rst) srst_q[0] && casc_q);
	c_err: cover property (@(posedge core_clk) disable iff (rst) pready && pslverr);

endmodule : tcu_target_cfg

// File: verification/tcu_target_cfg_tb.sv
// Self-checking bench for the trigger target configuration block.
// Assumes zero-wait APB answers and a local time counter driven here.
`timescale 1ns/1ps
`include "tcu_consts.svh"
module testbench;
	// Bus and time inputs
	logic core_clk = 1'b0;
	logic rst = 1'b1;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h00000000;
	logic [31:0] local_sec = 32'h00000000;
	logic [29:0] local_ns = 30'h00000000;
	// Design outputs
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic trig_out;
	logic trig_active;
	logic [4:0] delay_comp_ns;
	logic [23:0] pps_width_u12;
	// Notes {read, error, data}, one per transfer
	logic [17:0] notes [$];
	logic [17:0] note;
	int err_count = 0;
	int samples_checked = 0;
	logic [31:0] seed = 32'h000031cc;
	logic [9:0] rst_idx [9] = '{`TCU_IDX_NSL, `TCU_IDX_NSH, `TCU_IDX_SL, `TCU_IDX_SH,
		`TCU_IDX_CFG1, `TCU_IDX_PPS, `TCU_IDX_EN, `TCU_IDX_DONE, `TCU_IDX_ACTIVE};

	////////////////////////////////////////////////////////////////////////////////
	// Clock, 40 ns period
	always #20 core_clk = ~core_clk;

	tcu_target_cfg u_tcu_target_cfg (.core_clk(core_clk), .rst(rst), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .local_sec(local_sec),
		.local_ns(local_ns), .trig_out(trig_out), .trig_active(trig_active),
		.delay_comp_ns(delay_comp_ns), .pps_width_u12(pps_width_u12));

	////////////////////////////////////////////////////////////////////////////////
	// Shift register source of random data
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr

	// Counted compare
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		samples_checked++;
		if (got !== exp) begin
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
			err_count++;
		end
	endtask : chk

	// Verdict and end of run
	task automatic final_report;
		$display("checks %0d mismatches %0d", samples_checked, err_count);
		if (err_count == 0 && samples_checked > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : final_report

	// One APB transfer; idle cycle first so psel is never reassigned in one step
	task automatic apb(input logic wr, input logic [9:0] idx, input logic [15:0] wd,
		input logic [15:0] ed, input logic ee);
		int i;
		@(posedge core_clk);
		notes.push_back({~wr, ee, ed});
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= {idx, 2'b00};
		pwdata <= {16'h0000, wd};
		@(posedge core_clk);
		penable <= 1'b1;
		for (i = 0; i < 16; i++) begin
			@(posedge core_clk);
			if (pready === 1'b1) break;
		end
		if (i == 16) begin
			err_count++;
			final_report();
		end
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	// Short forms for write and checked read
	task automatic w(input logic [9:0] idx, input logic [15:0] d);
		apb(1'b1, idx, d, 16'h0000, 1'b0);
	endtask : w
	task automatic r(input logic [9:0] idx, input logic [15:0] e);
		apb(1'b0, idx, 16'h0000, e, 1'b0);
	endtask : r

	// Local time change at a rising edge
	task automatic set_time(input logic [31:0] s, input logic [29:0] n);
		@(posedge core_clk);
		local_sec <= s;
		local_ns <= n;
	endtask : set_time

	// Look for a trigger pulse within n cycles; a missing expected pulse ends the run
	task automatic wait_trig(input int n, input logic exp);
		int i;
		logic seen;
		seen = 1'b0;
		for (i = 0; i < n && !seen; i++) begin
			@(negedge core_clk);
			if (trig_out === 1'b1) seen = 1'b1;
		end
		chk("trig_out", {31'h0, exp}, {31'h0, seen});
		if (exp && !seen) final_report();
	endtask : wait_trig

	////////////////////////////////////////////////////////////////////////////////
	// Monitor: each completed transfer takes the oldest note
	always @(posedge core_clk) begin
		if (psel && penable && pready === 1'b1) begin
			if (notes.size() == 0) begin
				chk("note queue", 32'h1, 32'h0);
			end else begin
				note = notes.pop_front();
				if (note[17]) chk("prdata", {16'h0000, note[15:0]}, prdata);
				chk("pslverr", {31'h0, note[16]}, {31'h0, pslverr});
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		repeat (3) @(posedge core_clk);
		rst <= 1'b0;
		// Reset values
		foreach (rst_idx[k]) r(rst_idx[k], 16'h0000);
		$display("reset values done");
		// Target halves with random data
		for (int k = 0; k < 4; k++) begin
			seed = lfsr(seed);
			w(`TCU_IDX_NSL, seed[15:0]);
			r(`TCU_IDX_NSL, seed[15:0]);
			w(`TCU_IDX_NSH, seed[31:16]);
			r(`TCU_IDX_NSH, {2'b00, seed[29:16]});
			w(`TCU_IDX_SL, seed[31:16]);
			r(`TCU_IDX_SL, seed[31:16]);
			w(`TCU_IDX_SH, seed[15:0]);
			r(`TCU_IDX_SH, seed[15:0]);
		end
		w(`TCU_IDX_CFG1, 16'h8000);
		r(`TCU_IDX_CFG1, 16'h8000);
		w(`TCU_IDX_CFG1, 16'h0000);
		r(`TCU_IDX_CFG1, 16'h0000);
		$display("target registers done");
		// Every code in both ranges, and the unit 12 width
		for (int c = 0; c < 16; c++) begin
			seed = lfsr(seed);
			w(`TCU_IDX_PPS, {4'hf, c[3:0], seed[7:0]});
			r(`TCU_IDX_PPS, {4'h0, c[3:0], seed[7:0]});
			w(`TCU_IDX_U12W, seed[23:8]);
			// Combined width is registered once more after the store edge
			@(posedge core_clk);
			@(negedge core_clk);
			chk("delay_comp_ns", c[3] ? c[2:0] : {c[2:0], 2'b00}, delay_comp_ns);
			chk("pps_width_u12", {seed[7:0], seed[23:8]}, pps_width_u12);
		end
		$display("compensation done");
		// Unmapped place and read-only active register
		apb(1'b0, 10'h210, 16'h0000, 16'h0000, 1'b1);
		apb(1'b1, 10'h210, 16'hffff, 16'h0000, 1'b1);
		w(`TCU_IDX_ACTIVE, 16'hffff);
		r(`TCU_IDX_ACTIVE, 16'h0000);
		$display("refusals done");
		// Single fire at 5 s 100 ns plus 3 ns compensation
		w(`TCU_IDX_PPS, 16'h0b00);
		w(`TCU_IDX_NSL, 16'h0064);
		w(`TCU_IDX_NSH, 16'h0000);
		w(`TCU_IDX_SL, 16'h0005);
		w(`TCU_IDX_SH, 16'h0000);
		set_time(32'd5, 30'd102);
		w(`TCU_IDX_EN, 16'h0001);
		wait_trig(6, 1'b0);
		chk("trig_active", 32'h1, {31'h0, trig_active});
		set_time(32'd5, 30'd103);
		wait_trig(6, 1'b1);
		@(negedge core_clk);
		chk("trig_active", 32'h0, {31'h0, trig_active});
		r(`TCU_IDX_EN, 16'h0000);
		r(`TCU_IDX_DONE, 16'h0001);
		w(`TCU_IDX_DONE, 16'h0001);
		r(`TCU_IDX_DONE, 16'h0000);
		$display("single fire done");
		// Endless cascade loop, then soft reset stops it
		w(`TCU_IDX_CFG1, 16'h8000);
		set_time(32'd4, 30'd500);
		w(`TCU_IDX_EN, 16'h0001);
		wait_trig(6, 1'b0);
		set_time(32'd6, 30'd0);
		wait_trig(6, 1'b1);
		r(`TCU_IDX_EN, 16'h0001);
		wait_trig(4, 1'b0);
		set_time(32'd4, 30'd0);
		wait_trig(4, 1'b0);
		set_time(32'd7, 30'd0);
		wait_trig(6, 1'b1);
		w(`TCU_IDX_SRST, 16'h0001);
		r(`TCU_IDX_EN, 16'h0000);
		r(`TCU_IDX_CFG1, 16'h0000);
		r(`TCU_IDX_NSL, 16'h0000);
		r(`TCU_IDX_SL, 16'h0000);
		chk("trig_active", 32'h0, {31'h0, trig_active});
		set_time(32'd0, 30'd0);
		wait_trig(6, 1'b0);
		$display("cascade loop done");
		@(posedge core_clk);
		#1;
		final_report();
	end
endmodule : testbench
